/* File: rtl/uol_defs.vh */
// Register map, field positions and timing counts of the link reset and register access block
`ifndef UOL_DEFS_VH
`define UOL_DEFS_VH

// Register byte addresses
`define UOL_ADDR_SYSCFG 8'h00
`define UOL_ADDR_STATUS 8'h04
`define UOL_ADDR_PHYADDR 8'h08
`define UOL_ADDR_PHYDATA 8'h0c
`define UOL_ADDR_PHYCTRL 8'h10
`define UOL_ADDR_RXCTLH 8'h14
`define UOL_ADDR_SCRATCH 8'h18

// Field positions
`define UOL_SYSCFG_SOFTRST 1
`define UOL_PHYCTRL_GO 0
`define UOL_RXCTLH_DMA_AUTO_CLEAR_FEATURE 7
`define UOL_STAT_BUSY 0
`define UOL_STAT_RSTDONE 1
`define UOL_STAT_STOP 2
`define UOL_STAT_RXBYTE 8

// PHY reset commands and register write command
`define UOL_CMD_RESET_A 8'h69
`define UOL_CMD_RESET_B 8'h61
`define UOL_CMD_REGWR 8'h80

// Reset values
`define UOL_RXCTLH_RESET 8'h00

// Link clock rising edges counted down in the stop state before the stop pin can drop after a reset request
`define UOL_STOP_HOLD 4'h4

`endif

/* File: rtl/uol_link_reset.v */
// ULPI link reset sequencer with PHY register access path and register port
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "uol_defs.vh"

module uol_link_reset
#(
  parameter SELECT_ALT_CMD = 1'b0
)
(
  // Clock, reset, enable
  input wire clk,
  input wire reset_n,
  input wire clkEn,
  // Warm reset request from the system
  input wire warmReset,
  // Register port
  input wire [7:0] phy_reg_address_register,
  input wire [31:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdData,
  // ULPI link side
  input wire ulpiClk,
  input wire ulpiDir,
  input wire ulpiNxt,
  input wire [7:0] ulpiDataIn,
  output reg [7:0] ulpiDataOut,
  output reg ulpiDataOe,
  output reg ulpiStp,
  // Auto-clear control seen by the DMA logic
  output wire dmaAutoClear
);

  localparam ST_IDLE = 3'h0;
  localparam ST_STOP = 3'h1;
  localparam ST_CMD = 3'h2;
  localparam ST_PHY_REG_ADDRESS_REGISTER = 3'h3;
  localparam ST_PHY_REG_VALUE_REGISTER = 3'h4;
  localparam ST_END = 3'h5;

  // Synchronisers for pins from the link domain and for the warm reset request from the system
  reg [1:0] clkSync;
  reg [1:0] dirSync;
  reg [1:0] nxtSync;
  reg [7:0] dataSync0;
  reg [7:0] dataSync1;
  reg [1:0] warmSync;
  reg clkPrev;
  reg warmPrev;
  wire linkRise;
  wire warmEdge;

  // Registers
  reg [7:0] phyAddr;
  reg [7:0] phyValue;
  reg [7:0] rxCtlHigh;
  reg [31:0] scratch;
  reg resetDone;
  reg [2:0] state;
  reg [3:0] holdCnt;
  reg [7:0] cmdByte;
  reg pendReset;
  reg pendReg;
  reg coldPend;
  reg [7:0] rxByte;
  reg [31:0] statusWord;
  wire busy;
  wire [7:0] resetCmd;

  assign resetCmd = SELECT_ALT_CMD ? `UOL_CMD_RESET_B : `UOL_CMD_RESET_A;
  assign busy = (state != ST_IDLE);
  assign linkRise = clkSync[1] & ~clkPrev;
  assign warmEdge = warmSync[1] & ~warmPrev;
  assign dmaAutoClear = rxCtlHigh[`UOL_RXCTLH_DMA_AUTO_CLEAR_FEATURE];

  // Link clock sampler runs through reset, so a high clock at release is no false edge
  always @(posedge clk)
  begin
    if (clkEn)
    begin
      clkSync <= {clkSync[0], ulpiClk};
      clkPrev <= clkSync[1];
    end
  end

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      dirSync <= 2'h0;
      nxtSync <= 2'h0;
      dataSync0 <= 8'h00;
      dataSync1 <= 8'h00;
      warmSync <= 2'h0;
      warmPrev <= 1'b0;
    end
    else if (clkEn)
    begin
      dirSync <= {dirSync[0], ulpiDir};
      nxtSync <= {nxtSync[0], ulpiNxt};
      dataSync0 <= ulpiDataIn;
      dataSync1 <= dataSync0;
      warmSync <= {warmSync[0], warmReset};
      warmPrev <= warmSync[1];
    end
  end

  // Last byte the PHY drove while it owned the bus
  always @(posedge clk)
  begin
    if (!reset_n)
      rxByte <= 8'h00;
    else if (clkEn && linkRise && dirSync[1])
      rxByte <= dataSync1;
  end

  // Status word built from the field positions
  always @*
  begin
    statusWord = 32'h00000000;
    statusWord[`UOL_STAT_BUSY] = busy;
    statusWord[`UOL_STAT_RSTDONE] = resetDone;
    statusWord[`UOL_STAT_STOP] = ulpiStp;
    statusWord[`UOL_STAT_RXBYTE +: 8] = rxByte;
  end

  // Register port: access is served on every clkEn cycle, never gated by link or DMA activity
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      phyAddr <= 8'h00;
      phyValue <= 8'h00;
      rxCtlHigh <= `UOL_RXCTLH_RESET;
      scratch <= 32'h00000000;
      regRdData <= 32'h00000000;
    end
    else if (clkEn)
    begin
      if (regWrite)
      begin
        case (phy_reg_address_register)
          `UOL_ADDR_PHYADDR:
            phyAddr <= regWrData[7:0];
          `UOL_ADDR_PHYDATA:
            phyValue <= regWrData[7:0];
          `UOL_ADDR_RXCTLH:
            rxCtlHigh <= regWrData[7:0];
          `UOL_ADDR_SCRATCH:
            scratch <= regWrData;
          default:
            scratch <= scratch;
        endcase
      end
      if (regRead)
      begin
        case (phy_reg_address_register)
          `UOL_ADDR_SYSCFG:
            regRdData <= 32'h00000000;
          `UOL_ADDR_STATUS:
            regRdData <= statusWord;
          `UOL_ADDR_PHYADDR:
            regRdData <= {24'h0, phyAddr};
          `UOL_ADDR_PHYDATA:
            regRdData <= {24'h0, phyValue};
          `UOL_ADDR_RXCTLH:
            regRdData <= {24'h0, rxCtlHigh};
          `UOL_ADDR_SCRATCH:
            regRdData <= scratch;
          default:
            regRdData <= 32'h00000000;
        endcase
      end
      else
      begin
        regRdData <= 32'h00000000;
      end
    end
  end

  // Reset and register-write sequencer toward the PHY
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      holdCnt <= 4'h0;
      cmdByte <= 8'h00;
      pendReset <= 1'b0;
      pendReg <= 1'b0;
      coldPend <= 1'b1;
      resetDone <= 1'b0;
      ulpiStp <= 1'b0;
      ulpiDataOut <= 8'h00;
      ulpiDataOe <= 1'b0;
    end
    else if (clkEn)
    begin
      case (state)
        ST_IDLE:
        begin
          ulpiStp <= 1'b0;
          ulpiDataOe <= 1'b0;
          ulpiDataOut <= 8'h00;
          if (pendReset || coldPend)
          begin
            pendReset <= 1'b0;
            coldPend <= 1'b0;
            resetDone <= 1'b0;
            ulpiStp <= 1'b1;
            holdCnt <= `UOL_STOP_HOLD;
            state <= ST_STOP;
          end
          else if (pendReg && !dirSync[1])
          begin
            pendReg <= 1'b0;
            cmdByte <= `UOL_CMD_REGWR | {2'h0, phyAddr[5:0]};
            state <= ST_PHY_REG_ADDRESS_REGISTER;
          end
        end
        ST_STOP:
        begin
          if (linkRise)
          begin
            if (holdCnt != 4'h0)
              holdCnt <= holdCnt - 4'h1;
            else if (!dirSync[1])
            begin
              ulpiStp <= 1'b0;
              ulpiDataOut <= resetCmd;
              ulpiDataOe <= 1'b1;
              state <= ST_CMD;
            end
          end
        end
        ST_CMD:
        begin
          // PHY took the bus back: release it at once and resend from the stop state
          if (dirSync[1])
          begin
            ulpiDataOe <= 1'b0;
            ulpiDataOut <= 8'h00;
            holdCnt <= 4'h0;
            state <= ST_STOP;
          end
          // Command held until the PHY accepts it with next
          else if (linkRise && nxtSync[1])
          begin
            ulpiDataOe <= 1'b0;
            ulpiDataOut <= 8'h00;
            resetDone <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_PHY_REG_ADDRESS_REGISTER:
        begin
          // Turnaround aborts the access; it is retried whole once the bus is free
          if (dirSync[1])
          begin
            ulpiDataOe <= 1'b0;
            ulpiDataOut <= 8'h00;
            pendReg <= 1'b1;
            state <= ST_IDLE;
          end
          else
          begin
            ulpiDataOe <= 1'b1;
            ulpiDataOut <= cmdByte;
            if (linkRise && nxtSync[1])
            begin
              ulpiDataOut <= phyValue;
              state <= ST_PHY_REG_VALUE_REGISTER;
            end
          end
        end
        ST_PHY_REG_VALUE_REGISTER:
        begin
          if (dirSync[1])
          begin
            ulpiDataOe <= 1'b0;
            ulpiDataOut <= 8'h00;
            pendReg <= 1'b1;
            state <= ST_IDLE;
          end
          else if (linkRise && nxtSync[1])
          begin
            ulpiDataOe <= 1'b0;
            ulpiDataOut <= 8'h00;
            ulpiStp <= 1'b1;
            // Value equal to either reset command, 8'h69 or 8'h61, counts as a completed PHY reset
            if (phyValue == `UOL_CMD_RESET_A || phyValue == `UOL_CMD_RESET_B)
              resetDone <= 1'b1;
            state <= ST_END;
          end
        end
        ST_END:
        begin
          if (linkRise)
          begin
            ulpiStp <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
      // Requests follow the case, so a new one wins over the clear of the one being served
      // Soft reset bit self-clears; a request arriving mid-sequence is kept pending
      if ((regWrite && phy_reg_address_register == `UOL_ADDR_SYSCFG && regWrData[`UOL_SYSCFG_SOFTRST]) || warmEdge)
        pendReset <= 1'b1;
      if (regWrite && phy_reg_address_register == `UOL_ADDR_PHYCTRL && regWrData[`UOL_PHYCTRL_GO])
        pendReg <= 1'b1;
    end
  end

endmodule

/* File: tb/uol_link_reset_monitor.sv */
// Checker on the ports of the link reset block
`timescale 1ns/10ps
`include "uol_defs.vh"
module uol_link_reset_monitor(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Register port
  input wire [7:0] phy_reg_address_register,
  input wire [31:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regRdData,
  // Link side
  input wire ulpiDir,
  input wire [7:0] ulpiDataOut,
  input wire ulpiDataOe,
  input wire ulpiStp,
  input wire dmaAutoClear
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire softReq = regWrite && phy_reg_address_register == `UOL_ADDR_SYSCFG && regWrData[`UOL_SYSCFG_SOFTRST];
  chk_soft_stop: assert property (softReq |-> ##[1:2] ulpiStp)
    else $error("stop pin stayed low");
  chk_soft_cmd: assert property (softReq |-> ##[1:300] ulpiDataOe &&
    (ulpiDataOut == 8'h69 || ulpiDataOut == 8'h61)) else $error("reset command missing");
  chk_cold_stop: assert property ($rose(reset_n) |-> ##[0:2] ulpiStp)
    else $error("stop pin low after reset");
  chk_read_idle: assert property (!regRead |=> regRdData == 32'h0)
    else $error("read data outside slot");
  chk_auto_clear: assert property (regWrite && phy_reg_address_register == `UOL_ADDR_RXCTLH |=>
    dmaAutoClear == $past(regWrData[`UOL_RXCTLH_DMA_AUTO_CLEAR_FEATURE])) else $error("auto clear write lost");
  chk_dir_no_drive: assert property (ulpiDir [*4] |-> !ulpiDataOe)
    else $error("link drove during turnaround");
  cover property (softReq);
  cover property (ulpiDir && ulpiStp);
  cover property (regRead && phy_reg_address_register == `UOL_ADDR_SCRATCH);
  cover property ($fell(ulpiDataOe));
endmodule

/* File: tb/uol_phy_model.sv */
// Behavioural ULPI transceiver facing the link
`timescale 1ns/10ps
module uol_phy_model(
  // Pace of acceptance
  input wire slow,
  // PHY keeps the bus turned toward itself
  input wire busyDir,
  // Link pins
  input wire [7:0] ulpiDataOut,
  input wire ulpiDataOe,
  output reg ulpiClk,
  output reg ulpiDir,
  output reg ulpiNxt,
  output reg [7:0] ulpiDataIn,
  // Seen traffic
  output reg [7:0] firstByte,
  output reg [7:0] lastByte,
  output reg [7:0] frames
);
  reg oeSeen;
  initial
  begin
    ulpiClk = 1'b0;
    ulpiDir = 1'b0;
    ulpiNxt = 1'b0;
    ulpiDataIn = 8'h5a;
    frames = 8'h00;
    oeSeen = 1'b0;
  end
  // Transceiver clock runs free, as the PHY's own does
  always #40 ulpiClk = ~ulpiClk;
  always @(posedge ulpiClk)
  begin
    ulpiDataIn <= busyDir ? 8'h3c : ~ulpiDataIn;
    ulpiDir <= busyDir;
    ulpiNxt <= ulpiDataOe && !busyDir && (!slow || !ulpiNxt);
    if (ulpiDataOe && !oeSeen)
    begin
      firstByte <= ulpiDataOut;
      frames <= frames + 8'h01;
    end
    if (ulpiDataOe)
      lastByte <= ulpiDataOut;
    oeSeen <= ulpiDataOe;
  end
endmodule

/* File: tb/test_uol_link_reset.sv */
// Self-checking bench for the link reset block
`timescale 1ns/10ps
`include "uol_defs.vh"
module test_uol_link_reset;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg clkEn = 1'b1;
  reg warmReset = 1'b0;
  reg [7:0] phy_reg_address_register = 8'h00;
  reg [31:0] regWrData = 32'h0;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg slow = 1'b0;
  reg busyDir = 1'b0;
  wire [31:0] regRdData;
  wire ulpiClk, ulpiDir, ulpiNxt, ulpiDataOe, ulpiStp, dmaAutoClear;
  wire [7:0] ulpiDataIn, ulpiDataOut, firstByte, lastByte, frames;
  integer fails = 0;
  integer tests_run = 0;
  always #5 clk = ~clk;
  uol_link_reset u_dut(.clk(clk), .reset_n(reset_n), .clkEn(clkEn), .warmReset(warmReset),
    .phy_reg_address_register(phy_reg_address_register), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .ulpiClk(ulpiClk), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt),
    .ulpiDataIn(ulpiDataIn), .ulpiDataOut(ulpiDataOut), .ulpiDataOe(ulpiDataOe),
    .ulpiStp(ulpiStp), .dmaAutoClear(dmaAutoClear));
  uol_phy_model u_phy(.slow(slow), .busyDir(busyDir), .ulpiDataOut(ulpiDataOut), .ulpiDataOe(ulpiDataOe),
    .ulpiClk(ulpiClk), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt), .ulpiDataIn(ulpiDataIn),
    .firstByte(firstByte), .lastByte(lastByte), .frames(frames));
  task print_verdict;
  begin
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task check(input [31:0] got, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    regWrite <= 1'b1;
    phy_reg_address_register <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
  begin
    @(posedge clk);
    regRead <= 1'b1;
    phy_reg_address_register <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 check(regRdData, exp);
  end
  endtask
  // Frame count alone is not enough: the link must also be idle again
  task waitFrames(input [7:0] n);
    integer i;
  begin
    i = 0;
    while ((frames !== n || ulpiDataOe !== 1'b0 || ulpiStp !== 1'b0) && i < 800)
    begin
      @(posedge clk);
      i = i + 1;
    end
    if (i == 800)
    begin
      fails = fails + 1;
      print_verdict;
    end
  end
  endtask
  task coldBoot;
  begin
    waitFrames(8'h01);
    check(firstByte, 8'h69);
    rd(`UOL_ADDR_STATUS, 32'h2);
    rd(`UOL_ADDR_RXCTLH, 32'h0);
  end
  endtask
  task softBoot;
  begin
    wr(`UOL_ADDR_SYSCFG, 32'h2);
    @(posedge clk);
    #1 check(ulpiStp, 1'b1);
    wr(`UOL_ADDR_SCRATCH, 32'ha5c3_0f96);
    rd(`UOL_ADDR_SCRATCH, 32'ha5c3_0f96);
    wr(`UOL_ADDR_RXCTLH, 32'h80);
    rd(`UOL_ADDR_RXCTLH, 32'h80);
    check(dmaAutoClear, 1'b1);
    wr(`UOL_ADDR_RXCTLH, 32'h0);
    rd(`UOL_ADDR_SYSCFG, 32'h0);
    check(dmaAutoClear, 1'b0);
    rd(8'h1c, 32'h0);
    waitFrames(8'h02);
    check(firstByte, 8'h69);
  end
  endtask
  task warmBoot;
  begin
    @(posedge clk);
    warmReset <= 1'b1;
    repeat (4) @(posedge clk);
    warmReset <= 1'b0;
    waitFrames(8'h03);
    check(firstByte, 8'h69);
  end
  endtask
  task phyWrite;
  begin
    slow <= 1'b1;
    wr(`UOL_ADDR_PHYADDR, 32'h2a);
    wr(`UOL_ADDR_PHYDATA, 32'h61);
    wr(`UOL_ADDR_PHYCTRL, 32'h1);
    waitFrames(8'h04);
    check(firstByte, 8'haa);
    check(lastByte, 8'h61);
  end
  endtask
  // PHY holds the bus: the command waits with stop high, then goes once the bus is free
  task busyBus;
  begin
    busyDir <= 1'b1;
    wr(`UOL_ADDR_SYSCFG, 32'h2);
    repeat (120) @(posedge clk);
    #1 check(ulpiDataOe, 1'b0);
    check(ulpiStp, 1'b1);
    rd(`UOL_ADDR_STATUS, 32'h3c05);
    busyDir <= 1'b0;
    waitFrames(8'h05);
    check(firstByte, 8'h69);
    rd(`UOL_ADDR_STATUS, 32'h3c02);
  end
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    coldBoot;
    softBoot;
    warmBoot;
    phyWrite;
    busyBus;
    print_verdict;
  end
endmodule
bind uol_link_reset uol_link_reset_monitor u_mon(.clk(clk), .reset_n(reset_n), .phy_reg_address_register(phy_reg_address_register),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .ulpiDir(ulpiDir),
  .ulpiDataOut(ulpiDataOut), .ulpiDataOe(ulpiDataOe), .ulpiStp(ulpiStp), .dmaAutoClear(dmaAutoClear));
